// ==== verilog/fcs_pkg.sv ====
package fcs_pkg;
  // Register word indices on the Avalon-MM slave.
  localparam logic [2:0] FCS_REG_CTRL     = 3'h0;
  localparam logic [2:0] FCS_REG_FILTER   = 3'h1;
  localparam logic [2:0] FCS_REG_FREQCORR = 3'h2;
  localparam logic [2:0] FCS_REG_BITSYNC  = 3'h3;
  localparam logic [2:0] FCS_REG_STATUS   = 3'h4;
  localparam logic [2:0] FCS_REG_AVGFREQ  = 3'h5;
  localparam logic [2:0] FCS_REG_RXDATA   = 3'h6;

  // Field positions.
  localparam int FCS_CTRL_EN_BIT    = 0;
  localparam int FCS_MANT_LSB       = 0;
  localparam int FCS_EXP_LSB        = 4;
  localparam int FCS_LEN_LSB        = 6;
  localparam int FCS_ST_VALID_BIT   = 0;
  localparam int FCS_ST_NEMPTY_BIT  = 1;
  localparam int FCS_ST_FULL_BIT    = 2;
  localparam int FCS_ST_BIT_BIT     = 3;
  localparam int FCS_RXD_VALID_BIT  = 8;

  // Reset values and the samples-per-bit minimum.
  localparam logic       FCS_RST_EN       = 1'b0;
  localparam logic [4:0] FCS_RST_DIV      = 5'h18;
  localparam logic [3:0] FCS_RST_MANT     = 4'h4;
  localparam logic [1:0] FCS_RST_EXP      = 2'h0;
  localparam logic [1:0] FCS_RST_LEN      = 2'h1;
  localparam logic [7:0] FCS_RST_SPB      = 8'h08;
  localparam logic [7:0] FCS_MIN_SPB      = 8'h02;

  // Transitions needed before a slicing level is trusted.
  localparam logic [1:0] FCS_MIN_TRANS    = 2'h3;
  // Fixed-point scale of the decimator reciprocal table.
  localparam int FCS_RECIP_SHIFT          = 16;
  localparam int FCS_FIFO_DEPTH           = 8;
  localparam int FCS_FIFO_WIDTH           = 8;

  typedef enum logic [1:0] {
    FCS_AVG_OFF  = 2'b00,
    FCS_AVG_FAST = 2'b01,
    FCS_AVG_MED  = 2'b10,
    FCS_AVG_SLOW = 2'b11
  } fcs_avg_len_t;
endpackage : fcs_pkg

// ==== verilog/fcs_fifo.sv ====
`timescale 1ns/10ps
module fcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full_w;
  logic             empty_w;

  // The extra pointer bit tells full from empty when the indices meet.
  assign full_w      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty_w     = (wr_q == rd_q);
  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
    end else if (in_valid_i && !full_w) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (in_valid_i && !full_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else if (out_ready_i && !empty_w) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : fcs_fifo

// ==== verilog/fcs_top.sv ====
`timescale 1ns/10ps
module fcs_top
  import fcs_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic [2:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                demod_valid_i,
  input  wire logic [SAMPLE_W-1:0] demod_freq_i,
  output logic                     demod_ready_o,
  output logic                     rx_bit_o,
  output logic                     rx_bit_clk_o
);
  localparam int AW = SAMPLE_W + 5;
  localparam int RW = FCS_RECIP_SHIFT + 1;
  localparam int LW = SAMPLE_W + 1;

  // Configuration registers.
  logic       enable_q;
  logic [4:0] decimation_divider_q;
  logic [3:0] rx_deviation_mantissa_q;
  logic [1:0] rx_deviation_exponent_q;
  logic [1:0] slicer_averaging_length_q;
  logic [7:0] samples_per_bit_q;

  // Bus slave.
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        bus_req_w;
  logic        bus_done_w;

  // Datapath.
  logic                       ready_q;
  logic signed [AW-1:0]       acc_q;
  logic [4:0]                 dec_cnt_q;
  logic signed [SAMPLE_W-1:0] filt_q;
  logic                       filt_v_q;
  logic [RW-1:0]              recip_tab [32];
  logic signed [AW-1:0]       acc_sum_w;
  logic signed [AW+RW:0]      prod_w;

  logic signed [LW-1:0] max_q;
  logic signed [LW-1:0] min_q;
  logic signed [LW-1:0] ref_q;
  logic                 dir_up_q;
  logic                 started_q;
  logic [1:0]           trans_q;
  logic signed [LW-1:0] level_q;
  logic                 level_ok_q;
  logic signed [LW-1:0] samp_w;
  logic signed [LW-1:0] thr_w;
  logic signed [LW-1:0] mid_w;
  logic                 up_w;
  logic                 down_w;
  logic                 sliced_q;
  logic                 sliced_v_q;

  logic       prev_sl_q;
  logic [8:0] phase_q;
  logic [7:0] ones_q;
  logic [8:0] step_w;
  logic [8:0] ph_sum_w;
  logic [7:0] spb_w;
  logic       bit_end_w;
  logic       bit_w;
  logic [7:0] ones_w;

  logic [7:0] shift_q;
  logic [2:0] nbits_q;
  logic       push_q;
  logic [7:0] push_byte_q;
  logic       fifo_in_ready_w;
  logic       fifo_out_valid_w;
  logic [7:0] fifo_out_data_w;
  logic       pop_w;

  // Decimation table: one fixed-point reciprocal per divider setting.
  for (genvar g = 0; g < 32; g++) begin : g_recip
    assign recip_tab[g] = RW'((1 << FCS_RECIP_SHIFT) / (g + 1));
  end

  function automatic logic [31:0] field_read(input logic [2:0] addr,
                                             input logic [31:0] st,
                                             input logic [31:0] lvl,
                                             input logic [31:0] rxd);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      FCS_REG_CTRL:     v[FCS_CTRL_EN_BIT] = enable_q;
      FCS_REG_FILTER:   v[4:0] = decimation_divider_q;
      FCS_REG_FREQCORR: v[7:0] = {slicer_averaging_length_q, rx_deviation_exponent_q,
                                  rx_deviation_mantissa_q};
      FCS_REG_BITSYNC:  v[7:0] = samples_per_bit_q;
      FCS_REG_STATUS:   v = st;
      FCS_REG_AVGFREQ:  v = lvl;
      FCS_REG_RXDATA:   v = rxd;
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction : field_read

  // Avalon-MM: one wait cycle, then waitrequest low for exactly one cycle.
  assign bus_req_w  = avs_read_i || avs_write_i;
  assign bus_done_w = bus_req_w && !wait_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (bus_req_w && wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= field_read(avs_address_i,
                   {28'h0, rx_bit_o, !fifo_in_ready_w, fifo_out_valid_w, level_ok_q},
                   {{(32-LW){level_q[LW-1]}}, level_q},
                   {23'h0, fifo_out_valid_w, fifo_out_data_w});
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  assign pop_w = bus_done_w && avs_read_i && (avs_address_i == FCS_REG_RXDATA);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      enable_q                  <= FCS_RST_EN;
      decimation_divider_q      <= FCS_RST_DIV;
      rx_deviation_mantissa_q   <= FCS_RST_MANT;
      rx_deviation_exponent_q   <= FCS_RST_EXP;
      slicer_averaging_length_q <= FCS_RST_LEN;
      samples_per_bit_q         <= FCS_RST_SPB;
    end else if (bus_done_w && avs_write_i && avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        FCS_REG_CTRL:     enable_q <= avs_writedata_i[FCS_CTRL_EN_BIT];
        FCS_REG_FILTER:   decimation_divider_q <= avs_writedata_i[4:0];
        FCS_REG_FREQCORR: begin
          rx_deviation_mantissa_q   <= avs_writedata_i[FCS_MANT_LSB +: 4];
          rx_deviation_exponent_q   <= avs_writedata_i[FCS_EXP_LSB +: 2];
          slicer_averaging_length_q <= avs_writedata_i[FCS_LEN_LSB +: 2];
        end
        FCS_REG_BITSYNC:  begin
          // Fewer than two samples per bit leaves nothing to vote over.
          samples_per_bit_q <= (avs_writedata_i[7:0] < FCS_MIN_SPB) ?
                               FCS_MIN_SPB : avs_writedata_i[7:0];
        end
        default: ;
      endcase
    end
  end

  // Input throttle: a byte stuck at the FIFO stalls the sample source.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= enable_q && !(push_q && !fifo_in_ready_w);
    end
  end
  assign demod_ready_o = ready_q;

  // Boxcar decimator: average of divider+1 samples sets the bandwidth.
  assign acc_sum_w = acc_q + AW'(signed'(demod_freq_i));
  // Both factors are widened first so the product keeps its upper bits.
  assign prod_w    = (AW+RW+1)'(acc_sum_w) *
                     (AW+RW+1)'(signed'({1'b0, recip_tab[decimation_divider_q]}));

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      acc_q     <= '0;
      dec_cnt_q <= 5'h00;
      filt_q    <= '0;
      filt_v_q  <= 1'b0;
    end else begin
      filt_v_q <= 1'b0;
      if (demod_valid_i && ready_q) begin
        if (dec_cnt_q >= decimation_divider_q) begin
          filt_q    <= prod_w[FCS_RECIP_SHIFT +: SAMPLE_W];
          filt_v_q  <= 1'b1;
          acc_q     <= '0;
          dec_cnt_q <= 5'h00;
        end else begin
          acc_q     <= acc_sum_w;
          dec_cnt_q <= dec_cnt_q + 5'h01;
        end
      end
    end
  end

  // Slicer: extremes tracked between transitions larger than the deviation.
  assign samp_w = LW'(filt_q);
  assign thr_w  = LW'({rx_deviation_mantissa_q, 3'b000} >> (2'd3 - rx_deviation_exponent_q));
  assign up_w   = !dir_up_q && (samp_w > ref_q + thr_w);
  assign down_w = dir_up_q && (samp_w < ref_q - thr_w);
  assign mid_w  = LW'(((LW+1)'(max_q) + (LW+1)'(min_q)) >>> 1);

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      max_q     <= '0;
      min_q     <= '0;
      ref_q     <= '0;
      dir_up_q  <= 1'b0;
      started_q <= 1'b0;
      trans_q   <= 2'h0;
    end else if (filt_v_q) begin
      if (!started_q) begin
        started_q <= 1'b1;
        ref_q     <= samp_w;
      end else if (up_w) begin
        dir_up_q <= 1'b1;
        ref_q    <= samp_w;
        max_q    <= samp_w;
        if (trans_q != FCS_MIN_TRANS) trans_q <= trans_q + 2'h1;
      end else if (down_w) begin
        dir_up_q <= 1'b0;
        ref_q    <= samp_w;
        min_q    <= samp_w;
        if (trans_q != FCS_MIN_TRANS) trans_q <= trans_q + 2'h1;
      end else if (dir_up_q ? (samp_w > ref_q) : (samp_w < ref_q)) begin
        ref_q <= samp_w;
        if (dir_up_q) max_q <= samp_w;
        else          min_q <= samp_w;
      end
    end
  end

  // Decision level: first estimate after three transitions, then smoothed.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      level_q    <= '0;
      level_ok_q <= 1'b0;
    end else if (slicer_averaging_length_q == FCS_AVG_OFF) begin
      level_q    <= '0;
      level_ok_q <= 1'b0;
    end else if (filt_v_q && (up_w || down_w) && trans_q >= 2'h2) begin
      level_ok_q <= 1'b1;
      if (!level_ok_q) begin
        level_q <= mid_w;
      end else begin
        // Longer settings weight the history more heavily.
        level_q <= LW'(level_q + ((mid_w - level_q) >>>
                       {slicer_averaging_length_q, 1'b0}));
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      sliced_q   <= 1'b0;
      sliced_v_q <= 1'b0;
    end else begin
      sliced_v_q <= filt_v_q;
      if (filt_v_q) sliced_q <= samp_w > level_q;
    end
  end

  // Bit synchroniser: an edge in the late half advances the phase by one.
  assign spb_w     = samples_per_bit_q;
  // An advance that would end two bits in a row is skipped, so each bit gets a clock edge.
  assign step_w    = (sliced_q != prev_sl_q && phase_q >= 9'(spb_w >> 1)) ?
                     ((phase_q + 9'h003 < {spb_w, 1'b0}) ? 9'h002 : 9'h001) :
                     (sliced_q != prev_sl_q && phase_q != 9'h000) ? 9'h000 : 9'h001;
  assign ph_sum_w  = phase_q + step_w;
  assign bit_end_w = ph_sum_w >= 9'(spb_w);
  assign ones_w    = ones_q + 8'(sliced_q);
  assign bit_w     = {ones_w, 1'b0} > {1'b0, spb_w};

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      prev_sl_q <= 1'b0;
      phase_q   <= 9'h000;
      ones_q    <= 8'h00;
    end else if (sliced_v_q) begin
      prev_sl_q <= sliced_q;
      if (bit_end_w) begin
        phase_q <= ph_sum_w - 9'(spb_w);
        ones_q  <= 8'h00;
      end else begin
        phase_q <= ph_sum_w;
        ones_q  <= ones_w;
      end
    end
  end

  // Bit clock rises with each new bit and falls at mid-bit.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      rx_bit_o     <= 1'b0;
      rx_bit_clk_o <= 1'b0;
    end else if (sliced_v_q) begin
      if (bit_end_w) begin
        rx_bit_o     <= bit_w;
        rx_bit_clk_o <= 1'b1;
      end else if (ph_sum_w >= 9'(spb_w >> 1)) begin
        rx_bit_clk_o <= 1'b0;
      end
    end
  end

  // Bytes are packed first-received bit in the MSB.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_q) begin
      shift_q     <= 8'h00;
      nbits_q     <= 3'h0;
      push_q      <= 1'b0;
      push_byte_q <= 8'h00;
    end else begin
      if (push_q && fifo_in_ready_w) push_q <= 1'b0;
      if (sliced_v_q && bit_end_w) begin
        shift_q <= {shift_q[6:0], bit_w};
        nbits_q <= nbits_q + 3'h1;
        if (nbits_q == 3'h7) begin
          push_q      <= 1'b1;
          push_byte_q <= {shift_q[6:0], bit_w};
        end
      end
    end
  end

  fcs_fifo #(
    .WIDTH (FCS_FIFO_WIDTH),
    .DEPTH (FCS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_in_ready_w),
    .in_data_i   (push_byte_q),
    .out_valid_o (fifo_out_valid_w),
    .out_ready_i (pop_w),
    .out_data_o  (fifo_out_data_w)
  );
endmodule : fcs_top

// ==== tb/fcs_checker.sv ====
`timescale 1ns/10ps
module fcs_checker
  import fcs_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  input wire logic [2:0]          avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic [31:0]         avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire logic [31:0]         avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  input wire logic                demod_valid_i,
  input wire logic [SAMPLE_W-1:0] demod_freq_i,
  input wire logic                demod_ready_o,
  input wire logic                rx_bit_o,
  input wire logic                rx_bit_clk_o
);
  logic       en_q;
  logic [1:0] len_q;
  logic       wr_ok;
  logic       rd_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_ok = avs_read_i && !avs_waitrequest_o;

  // Shadows of enable and averaging length, taken at the edge a write completes.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      en_q  <= FCS_RST_EN;
      len_q <= FCS_RST_LEN;
    end else if (wr_ok && avs_address_i == FCS_REG_CTRL) begin
      en_q <= avs_writedata_i[FCS_CTRL_EN_BIT];
    end else if (wr_ok && avs_address_i == FCS_REG_FREQCORR) begin
      len_q <= avs_writedata_i[FCS_LEN_LSB+:2];
    end
  end

  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_answer_next: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late");
  a_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("long");
  a_no_spurious: assert property (
    !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i)) else $error("spurious answer");
  a_idle_quiet: assert property (
    !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o) else $error("idle");
  a_unmapped_zero: assert property (
    rd_ok && avs_address_i == 3'h7 |-> avs_readdata_o == 32'h0) else $error("unmapped data");
  // Disabling clears the bit with no clock edge, so only a running receiver is watched.
  a_bit_on_clk: assert property (
    en_q && $changed(rx_bit_o) |-> $rose(rx_bit_clk_o)) else $error("bit moved off clock");
  a_stopped_ready: assert property (
    !en_q && !$past(en_q) |-> !demod_ready_o) else $error("ready while disabled");
  a_off_no_valid: assert property (
    len_q == 2'h0 && rd_ok && avs_address_i == FCS_REG_STATUS
    |-> !avs_readdata_o[FCS_ST_VALID_BIT]) else $error("level valid while off");
  a_off_level_zero: assert property (
    len_q == 2'h0 && rd_ok && avs_address_i == FCS_REG_AVGFREQ
    |-> avs_readdata_o == 32'h0) else $error("level nonzero while off");

  c_byte: cover property (rd_ok && avs_address_i == FCS_REG_RXDATA && avs_readdata_o[8]);
  c_bit_clk: cover property ($rose(rx_bit_clk_o));
  c_stall: cover property (en_q && demod_valid_i && !demod_ready_o);
endmodule : fcs_checker

bind fcs_top fcs_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .demod_valid_i(demod_valid_i),
  .demod_freq_i(demod_freq_i), .demod_ready_o(demod_ready_o), .rx_bit_o(rx_bit_o),
  .rx_bit_clk_o(rx_bit_clk_o)
);

// ==== tb/fcs_tx_model.sv ====
`timescale 1ns/10ps
module fcs_tx_model #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       run_i,
  input  wire logic                       slow_i,
  input  wire logic                       ready_i,
  input  wire logic [7:0]                 pattern_i,
  input  wire logic signed [SAMPLE_W-1:0] center_i,
  input  wire logic signed [SAMPLE_W-1:0] dev_i,
  input  wire logic [15:0]                spb_i,
  output logic                            valid_o,
  output logic signed [SAMPLE_W-1:0]      freq_o
);
  logic [15:0] smp_q;
  logic [2:0]  bit_q;
  logic        pre_q;
  logic        cur_bit;
  // One alternating byte leads every frame, then the pattern repeats MSB first.
  assign cur_bit = pre_q ? bit_q[0] : pattern_i[3'h7 - bit_q];

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run_i) begin
      valid_o <= 1'b0;
      // An idle line toggles so that stale samples can never look valid.
      freq_o  <= (freq_o === center_i) ? ~center_i : center_i;
      smp_q   <= 16'h0;
      bit_q   <= 3'h0;
      pre_q   <= 1'b1;
    end else if (valid_o && ready_i && slow_i) begin
      valid_o <= 1'b0;
      freq_o  <= ~freq_o;
    end else if (!valid_o || ready_i) begin
      valid_o <= 1'b1;
      freq_o  <= cur_bit ? center_i + dev_i : center_i - dev_i;
      smp_q   <= (smp_q + 16'h1 == spb_i) ? 16'h0 : smp_q + 16'h1;
      if (smp_q + 16'h1 == spb_i) begin
        bit_q <= bit_q + 3'h1;
        pre_q <= pre_q && bit_q != 3'h7;
      end
    end
  end
endmodule : fcs_tx_model

// ==== tb/fcs_top_tb_top.sv ====
`timescale 1ns/10ps
module fcs_top_tb_top
  import fcs_pkg::*;
;
  logic               core_clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [2:0]         avs_address_i = 3'h0;
  logic               avs_read_i = 1'b0;
  logic               avs_write_i = 1'b0;
  logic [31:0]        avs_writedata_i = 32'h0;
  logic [3:0]         avs_byteenable_i = 4'hf;
  logic [31:0]        avs_readdata_o;
  logic               avs_waitrequest_o;
  logic               demod_valid_i;
  logic signed [11:0] demod_freq_i;
  logic               demod_ready_o;
  logic               rx_bit_o;
  logic               rx_bit_clk_o;
  logic               run = 1'b0;
  logic               slow = 1'b0;
  logic [7:0]         pattern = 8'ha5;
  logic signed [11:0] center = 12'h000;
  logic [15:0]        spb = 16'h0010;
  logic [31:0]        rd;
  int                 n_errors = 0;
  int                 num_checks = 0;

  fcs_top #(.SAMPLE_W(12)) u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .demod_valid_i(demod_valid_i),
    .demod_freq_i(demod_freq_i), .demod_ready_o(demod_ready_o), .rx_bit_o(rx_bit_o),
    .rx_bit_clk_o(rx_bit_clk_o)
  );
  fcs_tx_model #(.SAMPLE_W(12)) u_tx (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow),
    .ready_i(demod_ready_o), .pattern_i(pattern), .center_i(center), .dev_i(12'h028),
    .spb_i(spb), .valid_o(demod_valid_i), .freq_o(demod_freq_i)
  );

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic timeout();
    $display("unexpected wait limit at %0t: seen 0x0 expected 0x1", $time);
    n_errors++;
    close_out();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  // Outputs are read right after the edge, so they hold their pre-edge values.
  task automatic bus(input logic we, input logic [2:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= we;
    avs_read_i      <= !we;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (n == 50) timeout();
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic get_byte(output logic [7:0] b);
    int n;
    for (n = 0; n < 3000; n++) begin
      bus(1'b0, FCS_REG_RXDATA, 32'h0);
      if (rd[FCS_RXD_VALID_BIT] === 1'b1) break;
    end
    if (n == 3000) timeout();
    b = rd[7:0];
  endtask : get_byte

  task automatic wait_rise(output int c);
    logic p;
    for (c = 1; c < 5000; c++) begin
      p = rx_bit_clk_o;
      @(posedge core_clk_i);
      if (p === 1'b0 && rx_bit_clk_o === 1'b1) break;
    end
    if (c == 5000) timeout();
  endtask : wait_rise

  task automatic start_rx(input logic [4:0] dv, input logic [7:0] sp, input logic [7:0] fc);
    bus(1'b1, FCS_REG_FILTER, {27'h0, dv});
    bus(1'b1, FCS_REG_BITSYNC, {24'h0, sp});
    bus(1'b1, FCS_REG_FREQCORR, {24'h0, fc});
    spb <= 16'(sp) * (16'(dv) + 16'h1);
    bus(1'b1, FCS_REG_CTRL, 32'h1);
    run <= 1'b1;
  endtask : start_rx

  // The byte buffer survives a disable, so it is emptied here.
  task automatic stop_rx();
    int n;
    bus(1'b1, FCS_REG_CTRL, 32'h0);
    run <= 1'b0;
    for (n = 0; n < 20; n++) begin
      bus(1'b0, FCS_REG_RXDATA, 32'h0);
      if (rd[FCS_RXD_VALID_BIT] !== 1'b1) break;
    end
  endtask : stop_rx

  task automatic t_regs();
    bus(1'b0, FCS_REG_FILTER, 32'h0);
    check({27'h0, rd[4:0]}, {27'h0, FCS_RST_DIV});
    avs_byteenable_i <= 4'he;
    bus(1'b1, FCS_REG_FILTER, 32'h0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, FCS_REG_FILTER, 32'h0);
    check({27'h0, rd[4:0]}, {27'h0, FCS_RST_DIV});
    bus(1'b0, FCS_REG_FREQCORR, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, FCS_RST_LEN, FCS_RST_EXP, FCS_RST_MANT});
    bus(1'b0, FCS_REG_BITSYNC, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, FCS_RST_SPB});
    bus(1'b1, 3'h7, 32'hffff_ffff);
    bus(1'b0, 3'h7, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, FCS_REG_BITSYNC, 32'h1);
    bus(1'b0, FCS_REG_BITSYNC, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, FCS_MIN_SPB});
  endtask : t_regs

  task automatic t_bandwidth();
    logic [4:0] dv [4];
    int c;
    int i;
    int k;
    dv = '{5'h00, 5'h0f, 5'h18, 5'h1f};
    pattern <= 8'hff;
    center  <= 12'h000;
    for (i = 0; i < 4; i++) begin
      start_rx(dv[i], 8'h02, 8'h44);
      for (k = 0; k < 11; k++) begin
        wait_rise(c);
      end
      check(32'(c), 32'(2 * (dv[i] + 1)));
      check({31'h0, rx_bit_o}, 32'h1);
      stop_rx();
    end
  endtask : t_bandwidth

  task automatic t_slice(input logic signed [11:0] cv, input logic [7:0] fc, input logic sl,
                         input logic [7:0] eb, input logic ev);
    logic [7:0] b;
    pattern <= 8'ha5;
    center  <= cv;
    slow    <= sl;
    start_rx(5'h01, 8'h04, fc);
    get_byte(b);
    get_byte(b);
    check({24'h0, b}, {24'h0, eb});
    bus(1'b0, FCS_REG_STATUS, 32'h0);
    check({31'h0, rd[FCS_ST_VALID_BIT]}, {31'h0, ev});
    bus(1'b0, FCS_REG_AVGFREQ, 32'h0);
    check(rd, ev ? {{20{cv[11]}}, cv} : 32'h0);
    stop_rx();
    slow <= 1'b0;
  endtask : t_slice

  task automatic t_fifo();
    int n;
    int cnt;
    pattern <= 8'ha5;
    center  <= 12'h000;
    start_rx(5'h00, 8'h02, 8'h44);
    for (n = 0; n < 400; n++) begin
      bus(1'b0, FCS_REG_STATUS, 32'h0);
      if (rd[FCS_ST_FULL_BIT] === 1'b1) break;
    end
    check({31'h0, rd[FCS_ST_FULL_BIT]}, 32'h1);
    for (n = 0; n < 100 && demod_ready_o !== 1'b0; n++) begin
      @(posedge core_clk_i);
    end
    check({31'h0, demod_ready_o}, 32'h0);
    run <= 1'b0;
    bus(1'b0, FCS_REG_RXDATA, 32'h0);
    check({23'h0, rd[8:0]}, 32'h155);
    for (cnt = 1; cnt < 12; cnt++) begin
      bus(1'b0, FCS_REG_RXDATA, 32'h0);
      if (rd[FCS_RXD_VALID_BIT] !== 1'b1) break;
      check({24'h0, rd[7:0]}, 32'ha5);
    end
    check({31'h0, rd[FCS_RXD_VALID_BIT]}, 32'h0);
    check(32'(cnt >= 8), 32'h1);
    bus(1'b0, FCS_REG_STATUS, 32'h0);
    check({31'h0, rd[FCS_ST_NEMPTY_BIT]}, 32'h0);
    stop_rx();
  endtask : t_fifo

  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_bandwidth();
    t_slice(12'h000, 8'h44, 1'b1, 8'ha5, 1'b1);
    t_slice(12'h032, 8'hc4, 1'b0, 8'ha5, 1'b1);
    t_slice(12'h032, 8'h04, 1'b0, 8'hff, 1'b0);
    t_slice(12'h032, 8'hbf, 1'b0, 8'hff, 1'b0);
    t_fifo();
    close_out();
  end
endmodule : fcs_top_tb_top
